/* hw/crcp_pkg.sv */
// shared constants for the logic cluster register control block
package crcp_pkg;

  // ==========================================================
  // bus geometry
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned STRB_W = DATA_W / 8;
  localparam int unsigned MAX_CELLS = 32;

  // ==========================================================
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CHAIN_SEL = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_CLEAR_SEL = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_CELL_STATE = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_CONFIG = 4'hC;

  // ==========================================================
  // reset values and field positions
  localparam logic [DATA_W-1:0] CHAIN_SEL_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] CLEAR_SEL_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;
  localparam int unsigned CFG_CELLS_LSB = 0;
  localparam int unsigned CFG_CELLS_W = 8;
  localparam int unsigned CFG_DEVCLR_BIT = 8;

  // ==========================================================
  // responses and cell values
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic CELL_CLEARED = 1'h0;
  localparam logic CELL_PRESET = 1'h1;
  localparam logic FLAG_SET = 1'h1;
  localparam logic FLAG_CLEAR = 1'h0;

endpackage

/* hw/crcp_top.sv */
// logic cluster registers with clear, preset, sync controls, chain and axi4-lite slave
//
// Notes on behaviour
// - cluster-wide signals drive all cell clears, presets
// - every cell register has async clear, preset
// - preset is async load of one, uninverted
// - clear beats preset when both asserted
// - two selectable clears, one preset per cluster
// - device-wide clear resets every cell register
// - device-wide clear overrides all; build-time enable
// - chain feeds each cell from previous cell
// - sync clear, sync load act cluster-wide
// - sync load captures load value, not data
`timescale 1ns/10ps

// ==========================================================
// one cell register
module crcp_cell (
  input wire logic clk,
  input wire logic reset,
  input wire logic async_clear,
  input wire logic async_preset,
  input wire logic sync_clear,
  input wire logic sync_load,
  input wire logic load_value,
  input wire logic d,
  output logic q
);
  import crcp_pkg::*;

  // async controls sit in the sensitivity list so they act between edges
  always_ff @(posedge clk or posedge async_clear or posedge async_preset) begin
    if (async_clear) begin
      q <= CELL_CLEARED;
    end else if (async_preset) begin
      q <= CELL_PRESET;
    end else if (reset) begin
      q <= CELL_CLEARED;
    end else if (sync_clear) begin
      q <= CELL_CLEARED;
    end else if (sync_load) begin
      q <= load_value;
    end else begin
      q <= d;
    end
  end
endmodule

// ==========================================================
// cluster top
module crcp_top #(
  parameter int unsigned NUM_CELLS = 8,
  parameter bit USE_DEVICE_WIDE_CLEAR = 1'b1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [crcp_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [crcp_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [crcp_pkg::STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [crcp_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [crcp_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic device_wide_clear_n,
  input wire logic async_clear_0,
  input wire logic async_clear_1,
  input wire logic async_load,
  input wire logic sync_clear,
  input wire logic sync_load,
  input wire logic chain_in,
  input wire logic [NUM_CELLS-1:0] data_in,
  input wire logic [NUM_CELLS-1:0] load_data,
  output logic [NUM_CELLS-1:0] cell_q,
  output logic chain_out
);
  import crcp_pkg::*;

  generate
    if (NUM_CELLS < 1 || NUM_CELLS > MAX_CELLS) begin : g_bad_cells
      $error("NUM_CELLS must be 1 to 32");
    end
  endgenerate

  // ==========================================================
  // software registers
  logic [NUM_CELLS-1:0] chain_sel_reg;
  logic [NUM_CELLS-1:0] clear_sel_reg;
  logic [NUM_CELLS-1:0] chain_sel_next;
  logic [NUM_CELLS-1:0] clear_sel_next;

  // ==========================================================
  // cluster control fan-out
  wire device_clear_hit = USE_DEVICE_WIDE_CLEAR && !device_wide_clear_n;
  wire [NUM_CELLS:0] chain_tap;
  wire [NUM_CELLS-1:0] cell_aclr;
  wire [NUM_CELLS-1:0] cell_apre;
  wire [NUM_CELLS-1:0] cell_d;

  assign chain_tap[0] = chain_in;
  assign chain_tap[NUM_CELLS:1] = cell_q;
  assign chain_out = cell_q[NUM_CELLS-1];

  genvar i;
  generate
    for (i = 0; i < NUM_CELLS; i++) begin : g_cell
      // each cell picks one of the two shared clears
      wire picked_clear = clear_sel_reg[i] ? async_clear_1 : async_clear_0;
      assign cell_aclr[i] = device_clear_hit | picked_clear;
      // masking preset keeps the device clear dominant even on glitches
      assign cell_apre[i] = async_load & ~cell_aclr[i];
      // chain path skips the data input entirely
      assign cell_d[i] = chain_sel_reg[i] ? chain_tap[i] : data_in[i];
      crcp_cell u_cell (
        .clk(clk),
        .reset(reset),
        .async_clear(cell_aclr[i]),
        .async_preset(cell_apre[i]),
        .sync_clear(sync_clear),
        .sync_load(sync_load),
        .load_value(load_data[i]),
        .d(cell_d[i]),
        .q(cell_q[i])
      );
    end
  endgenerate

  // ==========================================================
  // write channel
  logic aw_got_reg;
  logic w_got_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [DATA_W-1:0] w_data_reg;
  logic [STRB_W-1:0] w_strb_reg;
  logic [DATA_W-1:0] strb_mask;

  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire b_done = s_axi_bvalid & s_axi_bready;
  wire do_write = aw_got_reg & w_got_reg & ~s_axi_bvalid;
  wire [ADDR_W-3:0] wr_word = aw_addr_reg[ADDR_W-1:2];
  wire wr_chain = wr_word == OFF_CHAIN_SEL[ADDR_W-1:2];
  wire wr_clear = wr_word == OFF_CLEAR_SEL[ADDR_W-1:2];
  wire wr_ro = (wr_word == OFF_CELL_STATE[ADDR_W-1:2]) | (wr_word == OFF_CONFIG[ADDR_W-1:2]);
  wire wr_mapped = wr_chain | wr_clear | wr_ro;

  genvar b;
  generate
    for (b = 0; b < STRB_W; b++) begin : g_strb
      assign strb_mask[b*8 +: 8] = {8{w_strb_reg[b]}};
    end
  endgenerate

  wire [DATA_W-1:0] chain_merged =
    (DATA_W'(chain_sel_reg) & ~strb_mask) | (w_data_reg & strb_mask);
  wire [DATA_W-1:0] clear_merged =
    (DATA_W'(clear_sel_reg) & ~strb_mask) | (w_data_reg & strb_mask);

  assign chain_sel_next = (do_write && wr_chain) ? chain_merged[NUM_CELLS-1:0] : chain_sel_reg;
  assign clear_sel_next = (do_write && wr_clear) ? clear_merged[NUM_CELLS-1:0] : clear_sel_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      chain_sel_reg <= CHAIN_SEL_RESET[NUM_CELLS-1:0];
      clear_sel_reg <= CLEAR_SEL_RESET[NUM_CELLS-1:0];
    end else begin
      chain_sel_reg <= chain_sel_next;
      clear_sel_reg <= clear_sel_next;
    end
  end

  // address and data are held until both are in, in either order
  always_ff @(posedge clk) begin
    if (reset) begin
      s_axi_awready <= FLAG_SET;
      s_axi_wready <= FLAG_SET;
      aw_got_reg <= FLAG_CLEAR;
      w_got_reg <= FLAG_CLEAR;
      s_axi_bvalid <= FLAG_CLEAR;
      s_axi_bresp <= RESP_OKAY;
      aw_addr_reg <= OFF_CHAIN_SEL;
      w_data_reg <= DATA_ZERO;
      w_strb_reg <= '0;
    end else begin
      if (aw_take) begin
        s_axi_awready <= FLAG_CLEAR;
        aw_got_reg <= FLAG_SET;
        aw_addr_reg <= s_axi_awaddr;
      end else if (do_write) begin
        aw_got_reg <= FLAG_CLEAR;
      end else if (b_done) begin
        s_axi_awready <= FLAG_SET;
      end
      if (w_take) begin
        s_axi_wready <= FLAG_CLEAR;
        w_got_reg <= FLAG_SET;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (do_write) begin
        w_got_reg <= FLAG_CLEAR;
      end else if (b_done) begin
        s_axi_wready <= FLAG_SET;
      end
      if (do_write) begin
        s_axi_bvalid <= FLAG_SET;
        s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (b_done) begin
        s_axi_bvalid <= FLAG_CLEAR;
      end
    end
  end

  // ==========================================================
  // read channel
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire r_done = s_axi_rvalid & s_axi_rready;
  wire [ADDR_W-3:0] rd_word = s_axi_araddr[ADDR_W-1:2];
  wire rd_chain = rd_word == OFF_CHAIN_SEL[ADDR_W-1:2];
  wire rd_clear = rd_word == OFF_CLEAR_SEL[ADDR_W-1:2];
  wire rd_state = rd_word == OFF_CELL_STATE[ADDR_W-1:2];
  wire rd_config = rd_word == OFF_CONFIG[ADDR_W-1:2];
  wire [DATA_W-1:0] config_word =
    (DATA_W'(NUM_CELLS[CFG_CELLS_W-1:0]) << CFG_CELLS_LSB) |
    (DATA_W'(USE_DEVICE_WIDE_CLEAR) << CFG_DEVCLR_BIT);
  wire [DATA_W-1:0] rd_value =
    rd_chain ? DATA_W'(chain_sel_reg) :
    rd_clear ? DATA_W'(clear_sel_reg) :
    rd_state ? DATA_W'(cell_q) :
    rd_config ? config_word : DATA_ZERO;
  wire rd_mapped = rd_chain | rd_clear | rd_state | rd_config;

  always_ff @(posedge clk) begin
    if (reset) begin
      s_axi_arready <= FLAG_SET;
      s_axi_rvalid <= FLAG_CLEAR;
      s_axi_rdata <= DATA_ZERO;
      s_axi_rresp <= RESP_OKAY;
    end else if (ar_take) begin
      s_axi_arready <= FLAG_CLEAR;
      s_axi_rvalid <= FLAG_SET;
      s_axi_rdata <= rd_value;
      s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (r_done) begin
      s_axi_rvalid <= FLAG_CLEAR;
      s_axi_arready <= FLAG_SET;
    end
  end
endmodule

/* tb/crcp_user.sv */
// user logic partner that drives the cluster control pins
`timescale 1ns/10ps
module crcp_user (
  input wire logic clk,
  input wire logic [6:0] ctl_next,
  input wire logic [15:0] dat_next,
  output logic device_wide_clear_n,
  output logic async_clear_0,
  output logic async_clear_1,
  output logic async_load,
  output logic sync_clear,
  output logic sync_load,
  output logic chain_in,
  output logic [7:0] data_in,
  output logic [7:0] load_data
);
  // registered, so controls move only just after an edge
  always_ff @(posedge clk) begin
    {device_wide_clear_n, async_clear_0, async_clear_1, async_load, sync_clear, sync_load,
      chain_in} <= ctl_next;
    {data_in, load_data} <= dat_next;
  end
endmodule

/* tb/crcp_asserts.sv */
// concurrent checks on the cluster register block
`timescale 1ns/10ps
module crcp_asserts #(
  parameter int unsigned NUM_CELLS = 8,
  parameter bit USE_DEVICE_WIDE_CLEAR = 1'b1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic device_wide_clear_n,
  input wire logic async_clear_0,
  input wire logic async_clear_1,
  input wire logic async_load,
  input wire logic sync_clear,
  input wire logic sync_load,
  input wire logic [NUM_CELLS-1:0] load_data,
  input wire logic [NUM_CELLS-1:0] cell_q,
  input wire logic chain_out
);
  // ====
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire dclr = USE_DEVICE_WIDE_CLEAR && !device_wide_clear_n;
  // no async control at all, so the sync path alone decides
  wire calm = !dclr && !async_clear_0 && !async_clear_1 && !async_load;
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence resp_wait;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  a_devclr_zero: assert property (dclr |-> cell_q == '0)
    else $error("device clear left a cell set");
  a_preset_ones: assert property (!dclr && !async_clear_0 && !async_clear_1 && async_load
    |-> cell_q == '1) else $error("preset not all ones");
  a_clear_wins: assert property (async_clear_0 && async_clear_1 |-> cell_q == '0)
    else $error("clear lost");
  a_sync_clear: assert property (calm && sync_clear |=> !calm || cell_q == '0)
    else $error("sync clear missed");
  a_sync_load: assert property (calm && sync_load && !sync_clear
    |=> !calm || cell_q == $past(load_data)) else $error("sync load missed");
  a_reset_clear: assert property (disable iff (1'b0) reset && calm |=> !calm || cell_q == '0)
    else $error("reset left a cell set");
  a_chain_tail: assert property (chain_out == cell_q[NUM_CELLS-1])
    else $error("chain out differs");
  a_write_resp: assert property (wr_take |=> resp_wait) else $error("write response late");
  a_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read response late");
endmodule
bind crcp_top crcp_asserts #(.NUM_CELLS(NUM_CELLS), .USE_DEVICE_WIDE_CLEAR(USE_DEVICE_WIDE_CLEAR))
  u_chk (.*);

/* tb/tb.sv */
// self-checking bench for the cluster register block
`timescale 1ns/10ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module tb;
  import crcp_pkg::*;
  logic clk = 0, reset = 1, go = 0;
  logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf;
  logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, chain_out;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic device_wide_clear_n, async_clear_0, async_clear_1, async_load, sync_clear, sync_load;
  logic chain_in;
  logic [6:0] ctl_next = 7'h44;
  logic [15:0] dat_next = 0;
  logic [7:0] data_in, load_data, cell_q, mq, csel = 0, ksel = 0;
  int failures = 0, checked = 0, cycles = 0;
  crcp_top dut (.*);
  crcp_user u_user (.*);
  initial forever #2 clk = ~clk;
  // ====
  // reference cells: async overlay on top of the clocked value
  wire [7:0] fm = {8{!device_wide_clear_n}} | {8{async_clear_0}} & ~ksel | {8{async_clear_1}} & ksel;
  wire [7:0] shown = (mq | {8{async_load}}) & ~fm;
  wire [7:0] nxt = reset || sync_clear ? 8'h00 : sync_load ? load_data :
    csel & {shown[6:0], chain_in} | ~csel & data_in;
  always @(posedge clk) mq <= (nxt | {8{async_load}}) & ~fm;
  always @(negedge clk) begin
    if (go) begin
      `CHK("cell_q", shown, cell_q)
      `CHK("chain_out", shown[7], chain_out)
    end
    if (++cycles > 6000) begin
      failures++;
      stop_test();
    end
  end
  task automatic stop_test;
    if (failures == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    fork
      begin
        do @(posedge clk); while (!s_axi_awready);
        s_axi_awvalid <= 0;
      end
      begin
        do @(posedge clk); while (!s_axi_wready);
        s_axi_wvalid <= 0;
      end
    join
    s_axi_bready <= 1;
    do @(posedge clk); while (!s_axi_bvalid);
    s_axi_bready <= 0;
    `CHK("bresp", RESP_OKAY, s_axi_bresp)
  endtask
  task automatic rchk(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge clk); while (!s_axi_rvalid);
    s_axi_rready <= 0;
    `CHK("rdata", e, s_axi_rdata)
    `CHK("rresp", RESP_OKAY, s_axi_rresp)
  endtask
  initial begin
    void'($urandom(52809));
    repeat (10) @(posedge clk);
    reset <= 0;
    go <= 1;
    rchk(OFF_CHAIN_SEL, 0);
    rchk(OFF_CLEAR_SEL, 0);
    wr(OFF_CONFIG, 0);
    wr(OFF_CELL_STATE, 32'hffff_ffff);
    rchk(OFF_CONFIG, 32'h0000_0108);
    // a strobe on a byte above the cell count must leave the select untouched
    s_axi_wstrb <= 4'h2;
    wr(OFF_CHAIN_SEL, 32'hffff_ffff);
    s_axi_wstrb <= 4'hf;
    rchk(OFF_CHAIN_SEL, 0);
    repeat (4) begin
      // sync clear held while selects change, so the select timing cannot matter
      ctl_next <= 7'h44;
      d = $urandom;
      wr(OFF_CHAIN_SEL, d);
      csel = d[7:0];
      rchk(OFF_CHAIN_SEL, d & 32'h0000_00ff);
      d = $urandom;
      wr(OFF_CLEAR_SEL, d);
      ksel = d[7:0];
      rchk(OFF_CLEAR_SEL, d & 32'h0000_00ff);
      repeat (200) begin
        @(posedge clk);
        ctl_next <= {$urandom_range(7) != 0, $urandom_range(5) == 0, $urandom_range(5) == 0,
          $urandom_range(4) == 0, $urandom_range(3) == 0, $urandom_range(2) == 0, 1'($urandom)};
        dat_next <= 16'($urandom);
      end
      @(posedge clk);
      ctl_next <= 7'h42;
      repeat (3) @(posedge clk);
      rchk(OFF_CELL_STATE, {24'h0, shown});
    end
    // second reset mid-run: selects return to zero and cells clear under sync load
    reset <= 1;
    csel = 0;
    ksel = 0;
    repeat (2) @(posedge clk);
    reset <= 0;
    rchk(OFF_CHAIN_SEL, 0);
    rchk(OFF_CLEAR_SEL, 0);
    stop_test();
  end
endmodule
